// [tb/srex_exec_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module srex_exec_assertions (
	input wire logic                      clk_i,
	input wire logic                      rst_i,
	input wire srex_pkg::srex_wb_req_type wb_req_i,
	input wire srex_pkg::srex_wb_rsp_type wb_rsp_o,
	input wire logic                      busy_o
);
	import srex_pkg::*;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire logic rq = wb_req_i.cyc & wb_req_i.stb & ~wb_rsp_o.ack;
	wire logic st = rq & wb_req_i.we & wb_req_i.sel[0] & ~busy_o & (wb_req_i.adr == OFS_INSTR);
	wire logic rt = st & (wb_req_i.dat[15:1] == OPC_RETURN);
	wire logic rl = st & (wb_req_i.dat[15:10] == OPC_ROTL);
	wire logic rd = rq & ~wb_req_i.we & (wb_req_i.adr inside {OFS_WORK, OFS_FLAGS});
	AST_ROT_LEN: assert property (rl |=> busy_o [*4] ##1 !busy_o) else $error("rotate busy length");
	AST_RET_LEN: assert property (rt |=> busy_o [*8] ##1 !busy_o) else $error("return busy length");
	AST_ACK_NEXT: assert property (rq |=> wb_rsp_o.ack) else $error("ack late");
	AST_ACK_PULSE: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack) else $error("ack too long");
	AST_ACK_SPUR: assert property (!rq |=> !wb_rsp_o.ack) else $error("ack without request");
	AST_BUSY_IDLE: assert property (!busy_o && !st |=> !busy_o) else $error("busy without start");
	AST_BAD_OP: assert property (st && !rt && !rl |=> !busy_o) else $error("unknown opcode ran");
	AST_BYTE_HI: assert property (rd |=> wb_rsp_o.dat[31:8] == 24'h00_0000) else $error("byte upper bits");
	cover property (rl);
	cover property (rt && wb_req_i.dat[0]);
	cover property (rt && !wb_req_i.dat[0]);
endmodule : srex_exec_assertions
bind srex_exec srex_exec_assertions u_srex_exec_assertions (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i),
	.wb_rsp_o(wb_rsp_o), .busy_o(busy_o));
`default_nettype wire

// [tb/test_srex_exec.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; $display("ERROR %0t got %h exp %h", $time, g, e); end end
module test_srex_exec;
	import srex_pkg::*;
	logic            clk_i = 1'b0;
	logic            rst_i = 1'b1;
	srex_wb_req_type wb_req_i = '0;
	srex_wb_rsp_type wb_rsp_o;
	logic            busy_o;
	int              err_total = 0;
	int              tests_run = 0;
	logic [31:0]     q;
	logic [7:0]      f, m, w, fl, r;
	logic [3:0]      b;
	logic [11:0]     ib, ad;
	logic            d, a, x;
	always #12.5 clk_i = ~clk_i;
	srex_exec u_srex_exec (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o), .busy_o(busy_o));
	task automatic close_out;
		$display("tests %0d errors %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : close_out
	task automatic wb(input logic we, input logic [7:0] ofs, input logic [31:0] dt);
		int n;
		n = 0;
		wb_req_i <= '{1'b1, 1'b1, we, 4'hf, ofs, dt};
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_rsp_o.ack !== 1'b1 && n < 20);
		`CHK(wb_rsp_o.ack, 1'b1)
		q = wb_rsp_o.dat;
		wb_req_i <= '0;
		@(posedge clk_i);
	endtask : wb
	task automatic idle;
		for (int n = 0; n < 20 && busy_o !== 1'b0; n++) @(posedge clk_i);
		`CHK(busy_o, 1'b0)
	endtask : idle
	function automatic logic [11:0] ea(logic ab, logic xe, logic [7:0] fa, logic [3:0] bs, logic [11:0] ix);
		if (ab) return {bs, fa};
		if (xe && fa <= IDX_LIMIT) return ix + 12'(fa);
		return (fa >= ACC_SPLIT) ? {ACC_HI_BANK, fa} : {4'h0, fa};
	endfunction : ea
	initial begin
		#125000;
		err_total++;
		close_out;
	end
	initial begin
		void'($urandom(32'h3663));
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 24; i++) begin
			{f, m, w, fl, b, ib, d, a, x} = 51'({$urandom, $urandom});
			if (i < 4) begin
				f = i[1] ? ACC_SPLIT : IDX_LIMIT;
				a = 1'b0;
				x = i[0];
			end
			ad = ea(a, x, f, b, ib);
			wb(1, OFS_WORK, 32'(w));
			wb(1, OFS_FLAGS, 32'(fl));
			wb(1, OFS_BSR, 32'(b));
			wb(1, OFS_IDXBASE, 32'(ib));
			wb(1, OFS_CONFIG, 32'(x));
			wb(1, OFS_MEMADDR, 32'(ad));
			wb(1, OFS_MEMDATA, 32'(m));
			wb(1, OFS_INSTR, {16'h0000, OPC_ROTL, d, a, f});
			// Ignored, arrives while busy
			wb(1, OFS_WORK, 32'h0000_00a5);
			idle;
			r = {m[6:0], fl[FLAG_C]};
			wb(0, OFS_WORK, 0);
			`CHK(q, 32'(d ? w : r))
			wb(0, OFS_MEMDATA, 0);
			`CHK(q, 32'(d ? r : m))
			fl[FLAG_C] = m[7];
			fl[FLAG_Z] = (r == 8'h00);
			fl[FLAG_N] = r[7];
			wb(0, OFS_FLAGS, 0);
			`CHK(q, 32'(fl))
		end
		wb(1, OFS_STACK, 32'h0001_2345);
		wb(1, OFS_STACK, 32'h001f_fffe);
		wb(0, OFS_STACK, 0);
		`CHK(q, 32'h021f_fffe)
		for (int s = 0; s < 3; s++) begin
			{w, fl, b} = 20'($urandom);
			wb(1, OFS_WSHAD, 32'(w));
			wb(1, OFS_FSHAD, 32'(fl));
			wb(1, OFS_BSHAD, 32'(b));
			wb(1, OFS_WORK, 32'h0000_005a);
			wb(1, OFS_FLAGS, 32'h0000_0015);
			wb(1, OFS_BSR, 32'h0000_0003);
			wb(1, OFS_INSTR, {16'h0000, OPC_RETURN, s[0]});
			wb(0, OFS_INSTR, 0);
			`CHK(q[STAT_BUSY], 1'b1)
			idle;
			wb(0, OFS_PC, 0);
			`CHK(q, (s == 0) ? 32'h001f_fffe : (s == 1) ? 32'h0001_2345 : 32'h0000_0000)
			wb(0, OFS_WORK, 0);
			`CHK(q, s[0] ? 32'(w) : 32'h0000_005a)
			wb(0, OFS_FLAGS, 0);
			`CHK(q, s[0] ? 32'(fl) : 32'h0000_0015)
			wb(0, OFS_BSR, 0);
			`CHK(q, s[0] ? 32'(b) : 32'h0000_0003)
		end
		// Reset in the middle of a return
		wb(1, OFS_STACK, 32'h0000_0abc);
		wb(1, OFS_INSTR, {16'h0000, OPC_RETURN, 1'b1});
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(0, OFS_STACK, 0);
		`CHK(q, 32'h0000_0000)
		wb(0, OFS_PC, 0);
		`CHK(q, 32'h0000_0000)
		wb(0, OFS_INSTR, 0);
		`CHK(q, 32'h0000_0000)
		wb(1, OFS_INSTR, 32'h0000_ffff);
		wb(0, OFS_INSTR, 0);
		`CHK(q[STAT_BADOP], 1'b1)
		wb(0, 8'h34, 0);
		`CHK(q, 32'h0000_0000)
		close_out;
	end
endmodule : test_srex_exec
`default_nettype wire

// [verilog/srex_exec.sv]
// Local design decisions: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module srex_exec (
	input  wire logic                      clk_i,
	input  wire logic                      rst_i,
	input  wire srex_pkg::srex_wb_req_type wb_req_i,
	output var  srex_pkg::srex_wb_rsp_type wb_rsp_o,
	output var  logic                      busy_o
);
	import srex_pkg::*;

	// Stack pointer must count one past the deepest entry
	if (STACK_DEPTH >= (1 << SP_W) || DM_AW != 12) begin : g_size_check
		$error("srex_exec: unsupported stack or memory size");
	end

	typedef struct packed {
		srex_state_type     st;
		logic [1:0]         q;
		logic               cyc2;
		logic               badop;
		logic               busy;
		logic [15:0]        opc;
		logic [7:0]         operand;
		logic [7:0]         result;
		logic               c_new;
		logic [DM_AW-1:0]   eff_adr;
		logic [PC_W-1:0]    pc;
		logic [7:0]         work;
		logic [7:0]         flags;
		logic [7:0]         bank_select_reg;
		logic [7:0]         wshad;
		logic [7:0]         fshad;
		logic [7:0]         bshad;
		logic [SP_W-1:0]    sp;
		logic               ext_en;
		logic [DM_AW-1:0]   idx_base;
		logic [DM_AW-1:0]   mem_adr;
		logic               ack;
		logic [31:0]        rdat;
	} srex_regs_type;

	srex_regs_type       r_q;
	srex_regs_type       r_d;
	logic [7:0]          dmem [0:(1<<DM_AW)-1];
	logic [PC_W-1:0]     stack [0:STACK_DEPTH-1];
	logic                mem_we;
	logic [DM_AW-1:0]    mem_wadr;
	logic [7:0]          mem_wdat;
	logic                stk_we;
	logic [SP_W-1:0]     stk_wadr;
	logic [PC_W-1:0]     stk_wdat;
	logic                bus_go;
	logic                bus_wr;
	logic [PC_W-1:0]     stack_top_value;
	logic [7:0]          fsel;
	logic [DM_AW-1:0]    adr_calc;

	// One request per ack; the ack cycle itself is never taken
	assign bus_go = wb_req_i.cyc && wb_req_i.stb && !r_q.ack;
	// A write needs byte lane 0 selected; the other sel bits are not looked at
	assign bus_wr = bus_go && wb_req_i.we && wb_req_i.sel[0];
	// Empty stack pops as zero
	assign stack_top_value = (r_q.sp == '0) ? '0 : stack[r_q.sp - 1'b1];
	assign fsel = r_q.opc[7:0];

	// Effective data address of the rotate operand
	always_comb begin
		adr_calc = {BYTE_RST[3:0], fsel};
		if (r_q.opc[8]) begin
			adr_calc = {r_q.bank_select_reg[3:0], fsel};
		end else if (r_q.ext_en && fsel <= IDX_LIMIT) begin
			adr_calc = DM_AW'(r_q.idx_base + {4'h0, fsel});
		end else if (fsel >= ACC_SPLIT) begin
			adr_calc = {ACC_HI_BANK, fsel};
		end
	end

	always_comb begin
		r_d      = r_q;
		mem_we   = 1'b0;
		mem_wadr = r_q.mem_adr;
		mem_wdat = wb_req_i.dat[7:0];
		stk_we   = 1'b0;
		stk_wadr = r_q.sp;
		stk_wdat = PC_W'(wb_req_i.dat);
		r_d.ack  = bus_go;
		// Read data captured now, shown with the ack
		if (bus_go) begin
			case (wb_req_i.adr)
				OFS_INSTR:   r_d.rdat = 32'({r_q.badop, r_q.st != SRX_IDLE, r_q.opc});
				OFS_PC:      r_d.rdat = 32'(r_q.pc);
				OFS_WORK:    r_d.rdat = 32'(r_q.work);
				OFS_FLAGS:   r_d.rdat = 32'(r_q.flags);
				OFS_BSR:     r_d.rdat = 32'(r_q.bank_select_reg);
				OFS_WSHAD:   r_d.rdat = 32'(r_q.wshad);
				OFS_FSHAD:   r_d.rdat = 32'(r_q.fshad);
				OFS_BSHAD:   r_d.rdat = 32'(r_q.bshad);
				OFS_STACK:   r_d.rdat = 32'({r_q.sp, 3'h0, stack_top_value});
				OFS_CONFIG:  r_d.rdat = 32'(r_q.ext_en);
				OFS_IDXBASE: r_d.rdat = 32'(r_q.idx_base);
				OFS_MEMADDR: r_d.rdat = 32'(r_q.mem_adr);
				OFS_MEMDATA: r_d.rdat = 32'(dmem[r_q.mem_adr]);
				default:     r_d.rdat = 32'h0000_0000;
			endcase
		end
		// Software writes only while no instruction runs
		if (bus_wr && r_q.st == SRX_IDLE) begin
			case (wb_req_i.adr)
				OFS_INSTR: begin
					r_d.opc  = wb_req_i.dat[15:0];
					r_d.q    = 2'h0;
					r_d.cyc2 = 1'b0;
					if (wb_req_i.dat[15:1] == OPC_RETURN) begin
						r_d.st    = SRX_RET;
						r_d.badop = 1'b0;
					end else if (wb_req_i.dat[15:10] == OPC_ROTL) begin
						r_d.st    = SRX_ROT;
						r_d.badop = 1'b0;
					end else begin
						r_d.badop = 1'b1;
					end
				end
				OFS_PC:      r_d.pc = PC_W'(wb_req_i.dat);
				OFS_WORK:    r_d.work = wb_req_i.dat[7:0];
				OFS_FLAGS:   r_d.flags = wb_req_i.dat[7:0];
				OFS_BSR:     r_d.bank_select_reg = wb_req_i.dat[7:0];
				OFS_WSHAD:   r_d.wshad = wb_req_i.dat[7:0];
				OFS_FSHAD:   r_d.fshad = wb_req_i.dat[7:0];
				OFS_BSHAD:   r_d.bshad = wb_req_i.dat[7:0];
				OFS_STACK: begin
					if (r_q.sp < SP_W'(STACK_DEPTH)) begin
						stk_we = 1'b1;
						r_d.sp = r_q.sp + 1'b1;
					end
				end
				OFS_CONFIG:  r_d.ext_en = wb_req_i.dat[CFG_EXT];
				OFS_IDXBASE: r_d.idx_base = wb_req_i.dat[DM_AW-1:0];
				OFS_MEMADDR: r_d.mem_adr = wb_req_i.dat[DM_AW-1:0];
				OFS_MEMDATA: mem_we = 1'b1;
				default: ;
			endcase
		end
		// Phase counter wraps every four clocks
		if (r_q.st != SRX_IDLE) begin
			r_d.q = r_q.q + 1'b1;
		end
		case (r_q.st)
			// Q1 address, Q2 read, Q3 rotate, Q4 write back
			SRX_ROT: begin
				case (r_q.q)
					2'h0: r_d.eff_adr = adr_calc;
					2'h1: r_d.operand = dmem[r_q.eff_adr];
					2'h2: begin
						r_d.result = {r_q.operand[6:0], r_q.flags[FLAG_C]};
						r_d.c_new  = r_q.operand[7];
					end
					default: begin
						// Other flag bits keep their value
						r_d.flags[FLAG_C] = r_q.c_new;
						r_d.flags[FLAG_N] = r_q.result[7];
						r_d.flags[FLAG_Z] = (r_q.result == BYTE_RST);
						if (r_q.opc[9]) begin
							mem_we   = 1'b1;
							mem_wadr = r_q.eff_adr;
							mem_wdat = r_q.result;
						end else begin
							r_d.work = r_q.result;
						end
						r_d.st = SRX_IDLE;
					end
				endcase
			end
			// Pop in Q4 of the first cycle; the second cycle only idles
			SRX_RET: begin
				if (r_q.q == Q_LAST) begin
					if (r_q.cyc2) begin
						r_d.st = SRX_IDLE;
					end else begin
						r_d.cyc2 = 1'b1;
						r_d.pc   = stack_top_value;
						if (r_q.sp != '0) begin
							r_d.sp = r_q.sp - 1'b1;
						end
						if (r_q.opc[0]) begin
							r_d.work  = r_q.wshad;
							r_d.flags = r_q.fshad;
							r_d.bank_select_reg   = r_q.bshad;
						end
					end
				end
			end
			default: ;
		endcase
		if (rst_i) begin
			r_d         = '0;
			r_d.st      = SRX_IDLE;
			mem_we      = 1'b0;
			stk_we      = 1'b0;
		end
		// Registered copy so busy_o comes straight from a flop
		r_d.busy = (r_d.st != SRX_IDLE);
	end

	always_ff @(posedge clk_i) begin
		r_q <= r_d;
	end

	// Memories keep their contents through reset
	always_ff @(posedge clk_i) begin
		if (mem_we) begin
			dmem[mem_wadr] <= mem_wdat;
		end
		if (stk_we) begin
			stack[stk_wadr] <= stk_wdat;
		end
	end

	assign wb_rsp_o.ack = r_q.ack;
	assign wb_rsp_o.dat = r_q.rdat;
	assign busy_o       = r_q.busy;
endmodule : srex_exec
`default_nettype wire

// [verilog/srex_pkg.sv]
package srex_pkg;
	localparam int          PC_W         = 21;
	localparam int          DM_AW        = 12;
	localparam int          STACK_DEPTH  = 31;
	localparam int          SP_W         = 5;
	// Register byte offsets
	localparam logic [7:0]  OFS_INSTR    = 8'h00;
	localparam logic [7:0]  OFS_PC       = 8'h04;
	localparam logic [7:0]  OFS_WORK     = 8'h08;
	localparam logic [7:0]  OFS_FLAGS    = 8'h0c;
	localparam logic [7:0]  OFS_BSR      = 8'h10;
	localparam logic [7:0]  OFS_WSHAD    = 8'h14;
	localparam logic [7:0]  OFS_FSHAD    = 8'h18;
	localparam logic [7:0]  OFS_BSHAD    = 8'h1c;
	localparam logic [7:0]  OFS_STACK    = 8'h20;
	localparam logic [7:0]  OFS_CONFIG   = 8'h24;
	localparam logic [7:0]  OFS_IDXBASE  = 8'h28;
	localparam logic [7:0]  OFS_MEMADDR  = 8'h2c;
	localparam logic [7:0]  OFS_MEMDATA  = 8'h30;
	// Flag bit positions
	localparam int          FLAG_C       = 0;
	localparam int          FLAG_Z       = 2;
	localparam int          FLAG_N       = 4;
	// Status bits in the instruction register read value
	localparam int          STAT_BUSY    = 16;
	localparam int          STAT_BADOP   = 17;
	localparam int          CFG_EXT      = 0;
	// Opcode encodings
	localparam logic [14:0] OPC_RETURN   = 15'h0009;
	localparam logic [5:0]  OPC_ROTL     = 6'h0d;
	// Access bank split and indexed window
	localparam logic [7:0]  ACC_SPLIT    = 8'h60;
	localparam logic [7:0]  IDX_LIMIT    = 8'h5f;
	localparam logic [3:0]  ACC_HI_BANK  = 4'hf;
	localparam logic [1:0]  Q_LAST       = 2'h3;
	localparam logic [7:0]  BYTE_RST     = 8'h00;

	typedef enum logic [1:0] {
		SRX_IDLE = 2'b00,
		SRX_ROT  = 2'b01,
		SRX_RET  = 2'b11
	} srex_state_type;

	typedef struct packed {
		logic          cyc;
		logic          stb;
		logic          we;
		logic [3:0]    sel;
		logic [7:0]    adr;
		logic [31:0]   dat;
	} srex_wb_req_type;

	typedef struct packed {
		logic          ack;
		logic [31:0]   dat;
	} srex_wb_rsp_type;
endpackage : srex_pkg
